/* shared/uhb_regs.svh */
// Purpose: Named constants for the host bus port.
// Assumes: Included by bare name after the package.
// Notes:   Definitions only.
`ifndef UHB_REGS_SVH
`define UHB_REGS_SVH

// =====================================================================
// Register file layout
`define UHB_NREG        8     // Number of selectable registers
`define UHB_SEL_W       3     // Register select width
`define UHB_DATA_W      8     // Data bus width
`define UHB_IDX_MCR     3'h4  // Modem control register index
`define UHB_MCR_IRQ_EN  3     // Interrupt output enable bit
`define UHB_RST_BYTE    8'h00 // Reset value of every register
`define UHB_RST_SEL     3'h0  // Reset value of the select holders

// =====================================================================
// Control pin sample layout
`define UHB_CTL_IDLE    4'he  // Pins at rest: wr, rd, cs high, mode low
`define UHB_CTL_MODE    0     // Sample bit of the bus mode pin
`define UHB_CTL_CS      1     // Sample bit of the chip select
`define UHB_CTL_RD      2     // Sample bit of the read strobe
`define UHB_CTL_WR      3     // Sample bit of the write strobe or dir

`endif

/* shared/uhb_pkg.sv */
// Purpose: Types for the host bus port.
// Assumes: Nothing beyond the constants header.
// Notes:   Port state codes are Gray along idle-read and idle-write.
package uhb_pkg;

  // ===================================================================
  // Port sequencer states
  typedef enum logic [1:0] {
    UHB_ST_IDLE = 2'b00, // No access in progress
    UHB_ST_RD   = 2'b01, // Read access, bus driven
    UHB_ST_WR   = 2'b10  // Write access, waiting for end
  } uhb_state_t;

  typedef logic [7:0] uhb_byte_t; // One register byte
  typedef logic [2:0] uhb_sel_t;  // Register select value

endpackage : uhb_pkg

/* src/uhb_port.sv */
// Purpose: Parallel host register port of a UART, strobe or direction
//          line convention, sampled on the local clock.
// Assumes: Host strobes are slow against mclk_i; all pins asynchronous.
// Notes:   Two-way pins are split into input, output and output enable.
`timescale 1ns/1ps
`include "uhb_regs.svh"

module uhb_port (
  input  wire logic             mclk_i,        // Local clock, 100 MHz
  input  wire logic             rst_i,         // Sync reset, high
  input  wire logic             bus_mode_i,    // High strobes, low dir
  input  wire logic             cs_n_i,        // Chip select, low
  input  wire logic             read_strobe_n_i,  // Read strobe, low
  input  wire logic             write_strobe_n_i, // Write strobe or dir
  input  wire uhb_pkg::uhb_sel_t  reg_sel_i,   // Register select
  input  wire uhb_pkg::uhb_byte_t host_data_i, // Data bus, in
  output logic [7:0]            host_data_o,   // Data bus, out
  output logic                  host_data_oe_o,// Data bus drive
  input  wire logic             irq_req_i,     // Core interrupt request
  output logic                  irq_o,         // Interrupt pin level
  output logic                  irq_oe_o,      // Interrupt pin drive
  output logic                  wr_stb_o,      // Write done pulse
  output logic [2:0]            wr_sel_o,      // Last written select
  output logic [7:0]            wr_data_o      // Last written byte
);
  import uhb_pkg::*;

  // ===================================================================
  // Edge helpers
  function automatic logic rose(input logic now, input logic was);
    rose = now & ~was;
  endfunction : rose

  function automatic logic fell(input logic now, input logic was);
    fell = ~now & was;
  endfunction : fell

  // ===================================================================
  // Pin synchronisers
  logic [3:0] ctl_s1_r;   // First stage: mode, cs, rd, wr
  logic [3:0] ctl_s2_r;   // Second stage, safe to read
  uhb_sel_t   sel_s1_r;   // Select first stage
  uhb_sel_t   sel_s2_r;   // Select second stage
  uhb_sel_t   sel_s3_r;   // Select one sample older
  uhb_byte_t  dat_s1_r;   // Data first stage
  uhb_byte_t  dat_s2_r;   // Data second stage
  uhb_byte_t  dat_s3_r;   // Data one sample older

  // Every host bus pin passes two flops before any logic looks at it; irq_req_i and rst_i do not
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ctl_s1_r <= `UHB_CTL_IDLE;
      ctl_s2_r <= `UHB_CTL_IDLE;
      sel_s1_r <= `UHB_RST_SEL;
      sel_s2_r <= `UHB_RST_SEL;
      sel_s3_r <= `UHB_RST_SEL;
      dat_s1_r <= `UHB_RST_BYTE;
      dat_s2_r <= `UHB_RST_BYTE;
      dat_s3_r <= `UHB_RST_BYTE;
    end else begin
      ctl_s1_r <= {write_strobe_n_i, read_strobe_n_i, cs_n_i, bus_mode_i};
      ctl_s2_r <= ctl_s1_r;
      sel_s1_r <= reg_sel_i;
      sel_s2_r <= sel_s1_r;
      sel_s3_r <= sel_s2_r;
      dat_s1_r <= host_data_i;
      dat_s2_r <= dat_s1_r;
      dat_s3_r <= dat_s2_r;
    end
  end

  logic mode_s; // High selects strobe convention
  logic cs_s;   // Chip select, low active
  logic rd_s;   // Read strobe, low active
  logic wr_s;   // Write strobe or direction line
  assign mode_s = ctl_s2_r[`UHB_CTL_MODE];
  assign cs_s   = ctl_s2_r[`UHB_CTL_CS];
  assign rd_s   = ctl_s2_r[`UHB_CTL_RD];
  assign wr_s   = ctl_s2_r[`UHB_CTL_WR];

  // ===================================================================
  // Access decode
  logic rd_act; // A read access is under way
  logic wr_act; // A write access is under way

  // Both conventions reduce to one read and one write level
  always_comb begin
    if (cs_s) begin
      rd_act = 1'b0;
      wr_act = 1'b0;
    end else if (mode_s) begin
      rd_act = ~rd_s;
      wr_act = ~wr_s;
    end else begin
      rd_act = wr_s;
      wr_act = ~wr_s;
    end
  end

  // ===================================================================
  // Port sequencer and register file
  uhb_state_t state_r;            // Current access state
  uhb_state_t state_nxt;
  uhb_byte_t  regs_r   [`UHB_NREG]; // Register storage
  uhb_byte_t  regs_nxt [`UHB_NREG];
  uhb_byte_t  dout_r;             // Read data on the bus
  uhb_byte_t  dout_nxt;
  logic       doe_r;              // Bus drive enable
  logic       doe_nxt;
  logic       rd_act_r;           // Read level, one sample old
  logic       wstb_r;             // Write done pulse
  logic       wstb_nxt;
  uhb_sel_t   wsel_r;             // Written select
  uhb_sel_t   wsel_nxt;
  uhb_byte_t  wdat_r;             // Written byte
  uhb_byte_t  wdat_nxt;

  // Next state: start, hold and finish one access at a time
  always_comb begin
    state_nxt = state_r;
    regs_nxt  = regs_r;
    dout_nxt  = dout_r;
    doe_nxt   = 1'b0;
    wstb_nxt  = 1'b0;
    wsel_nxt  = wsel_r;
    wdat_nxt  = wdat_r;
    unique case (state_r)
      UHB_ST_IDLE: begin
        if (rd_act) begin
          // Read start: fetch selected byte and drive it
          dout_nxt  = regs_r[sel_s2_r];
          doe_nxt   = 1'b1;
          state_nxt = UHB_ST_RD;
        end else if (wr_act) begin
          // Write start: wait for the closing edge
          state_nxt = UHB_ST_WR;
        end
      end
      UHB_ST_RD: begin
        if (rd_act) begin
          doe_nxt = 1'b1;
        end else begin
          // Read end: let go of the bus
          state_nxt = UHB_ST_IDLE;
        end
      end
      UHB_ST_WR: begin
        if (!wr_act) begin
          // Closing edge: take the sample held while still active
          regs_nxt[sel_s3_r] = dat_s3_r;
          wstb_nxt  = 1'b1;
          wsel_nxt  = sel_s3_r;
          wdat_nxt  = dat_s3_r;
          state_nxt = UHB_ST_IDLE;
        end
      end
    endcase
  end

  // Register the sequencer
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state_r  <= UHB_ST_IDLE;
      for (int i = 0; i < `UHB_NREG; i++) begin
        regs_r[i] <= `UHB_RST_BYTE;
      end
      dout_r   <= `UHB_RST_BYTE;
      doe_r    <= 1'b0;
      rd_act_r <= 1'b0;
      wstb_r   <= 1'b0;
      wsel_r   <= `UHB_RST_SEL;
      wdat_r   <= `UHB_RST_BYTE;
    end else begin
      state_r  <= state_nxt;
      regs_r   <= regs_nxt;
      dout_r   <= dout_nxt;
      doe_r    <= doe_nxt;
      rd_act_r <= rd_act;
      wstb_r   <= wstb_nxt;
      wsel_r   <= wsel_nxt;
      wdat_r   <= wdat_nxt;
    end
  end

  // ===================================================================
  // Interrupt pin
  logic irq_r;    // Interrupt level
  logic irq_nxt;
  logic irqe_r;   // Interrupt drive enable
  logic irqe_nxt;

  // Strobe mode drives high-active when enabled, else open drain low
  always_comb begin
    if (mode_s) begin
      irq_nxt  = irq_req_i;
      irqe_nxt = regs_r[`UHB_IDX_MCR][`UHB_MCR_IRQ_EN];
    end else begin
      irq_nxt  = 1'b0;
      irqe_nxt = irq_req_i;
    end
  end

  // Register the interrupt pin
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      irq_r  <= 1'b0;
      irqe_r <= 1'b0;
    end else begin
      irq_r  <= irq_nxt;
      irqe_r <= irqe_nxt;
    end
  end

  // ===================================================================
  // Outputs, all from flops
  assign host_data_o    = dout_r;
  assign host_data_oe_o = doe_r;
  assign irq_o          = irq_r;
  assign irq_oe_o       = irqe_r;
  assign wr_stb_o       = wstb_r;
  assign wr_sel_o       = wsel_r;
  assign wr_data_o      = wdat_r;

  // ===================================================================
  // Checks
  logic rd_go;  // Read start seen this cycle
  assign rd_go = (state_r == UHB_ST_IDLE) & rd_act;

  a_read_drive: assert property (@(posedge mclk_i) disable iff (rst_i)
    rd_go |=> host_data_oe_o && host_data_o == $past(regs_r[sel_s2_r]))
    else $error("read start did not drive selected byte");
  a_bus_release: assert property (@(posedge mclk_i) disable iff (rst_i)
    fell(rd_act, rd_act_r) |=> !host_data_oe_o)
    else $error("bus held after read end");
  a_write_load: assert property (@(posedge mclk_i) disable iff (rst_i)
    state_r == UHB_ST_WR && !wr_act |=>
      regs_r[$past(sel_s3_r)] == $past(dat_s3_r) && wr_stb_o)
    else $error("write end did not load register");
  a_cs_ignore: assert property (@(posedge mclk_i) disable iff (rst_i)
    cs_s && state_r == UHB_ST_IDLE |=> state_r == UHB_ST_IDLE)
    else $error("access taken with chip select high");
  a_strobe_read: assert property (@(posedge mclk_i) disable iff (rst_i)
    mode_s && !cs_s && !rd_s && state_r == UHB_ST_IDLE
      |=> state_r == UHB_ST_RD ##1 host_data_oe_o)
    else $error("strobe read not started");
  a_strobe_write: assert property (@(posedge mclk_i) disable iff (rst_i)
    mode_s && !cs_s && rd_s && !wr_s && state_r == UHB_ST_IDLE
      |=> state_r == UHB_ST_WR)
    else $error("strobe write not started");
  a_dir_read: assert property (@(posedge mclk_i) disable iff (rst_i)
    !mode_s && !cs_s && wr_s && state_r == UHB_ST_IDLE
      |=> host_data_oe_o)
    else $error("direction read not started");
  a_cs_end: assert property (@(posedge mclk_i) disable iff (rst_i)
    !mode_s && state_r == UHB_ST_RD && cs_s
      |=> state_r == UHB_ST_IDLE ##1 !host_data_oe_o)
    else $error("chip select rise did not end read");
  a_irq_strobe: assert property (@(posedge mclk_i) disable iff (rst_i)
    mode_s |=> irq_o == $past(irq_req_i) &&
      irq_oe_o == $past(regs_r[`UHB_IDX_MCR][`UHB_MCR_IRQ_EN]))
    else $error("strobe mode interrupt pin wrong");
  a_irq_drain: assert property (@(posedge mclk_i) disable iff (rst_i)
    !mode_s |=> !irq_o && irq_oe_o == $past(irq_req_i))
    else $error("open drain interrupt pin wrong");

  c_strobe_rd: cover property (@(posedge mclk_i) disable iff (rst_i)
    mode_s && rd_go ##[1:50] fell(rd_act, rd_act_r));
  c_strobe_wr: cover property (@(posedge mclk_i) disable iff (rst_i)
    mode_s && wstb_r);
  c_dir_wr: cover property (@(posedge mclk_i) disable iff (rst_i)
    !mode_s && wstb_r);
  c_mcr_irq: cover property (@(posedge mclk_i) disable iff (rst_i)
    mode_s && irqe_r && irq_r);

endmodule : uhb_port

/* testbench/uhb_host.sv */
// Purpose: Host processor model that makes register accesses on the pins.
// Assumes: Pins change 1 ns after a rising clock edge.
// Notes:   The released data bus shows a pattern that changes every cycle.
`timescale 1ns/1ps
module uhb_host (
  input  wire logic       mclk_i,     // Bench clock
  input  wire logic [7:0] dev_data_i, // Device read data
  input  wire logic       dev_oe_i,   // Device drives the bus
  output logic            cs_n_o,     // Chip select, low
  output logic            rd_n_o,     // Read strobe, low
  output logic            wr_n_o,     // Write strobe or direction
  output logic [2:0]      sel_o,      // Register select
  output logic [7:0]      bus_o       // Resolved data bus
);
  logic       drv;  // Host drives the bus
  logic [7:0] hd;   // Host write byte
  logic [7:0] last = 8'h00; // Bus level one cycle ago, known from start

  // ===================================================================
  // Bus resolution; nobody driving gives the inverse of the last level
  assign bus_o = drv ? hd : (dev_oe_i ? dev_data_i : ~last);
  always @(posedge mclk_i) last <= bus_o;

  initial begin
    cs_n_o = 1'b1;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    sel_o  = 3'h0;
    hd     = 8'h00;
    drv    = 1'b0;
  end

  // ===================================================================
  // One access; strobe mode uses the strobes, direction mode uses cs
  task automatic access(input logic mode, input logic cs_en,
                        input logic is_rd, input logic [2:0] sel,
                        input logic [7:0] d, output logic [7:0] q);
    @(posedge mclk_i);
    #1;
    sel_o  = sel;
    hd     = d;
    drv    = !is_rd;
    wr_n_o = mode ? 1'b1 : is_rd;
    repeat (3) @(posedge mclk_i);
    #1;
    cs_n_o = !cs_en;
    if (mode) begin
      rd_n_o = !is_rd;
      wr_n_o = is_rd;
    end
    repeat (10) @(posedge mclk_i);
    q = bus_o;
    #1;
    cs_n_o = 1'b1;
    rd_n_o = 1'b1;
    if (mode) begin
      wr_n_o = 1'b1;
    end
    repeat (3) @(posedge mclk_i);
    #1;
    drv = 1'b0;
    repeat (4) @(posedge mclk_i);
  endtask : access
endmodule : uhb_host

/* testbench/testbench.sv */
// Purpose: Self-checking bench of the host register port.
// Assumes: Host model makes accesses; bench keeps a register model.
// Notes:   Strobe mode first, then direction mode.
`timescale 1ns/1ps
`include "uhb_regs.svh"
module testbench;
  import uhb_pkg::*;
  logic mclk_i = 1'b0, rst_i = 1'b1, bus_mode_i = 1'b1, irq_req_i = 1'b0;
  logic cs_n, rd_n, wr_n, oe, irq_o, irq_oe, wr_stb;
  logic [2:0] sel, wr_sel;
  logic [7:0] bus, dout, wr_data, q;
  int n_errors = 0, n_compared = 0, n_stb = 0, n_oe = 0, mdl[8];
  logic [31:0] rs = 32'h08d0; // Random state

  always #5 mclk_i = ~mclk_i;
  always @(posedge mclk_i) if (wr_stb === 1'b1) n_stb++;
  always @(posedge mclk_i) if (oe === 1'b1) n_oe++;

  uhb_port uhb_port_inst (.mclk_i(mclk_i), .rst_i(rst_i),
    .bus_mode_i(bus_mode_i), .cs_n_i(cs_n), .read_strobe_n_i(rd_n),
    .write_strobe_n_i(wr_n), .reg_sel_i(sel), .host_data_i(bus),
    .host_data_o(dout), .host_data_oe_o(oe), .irq_req_i(irq_req_i),
    .irq_o(irq_o), .irq_oe_o(irq_oe), .wr_stb_o(wr_stb),
    .wr_sel_o(wr_sel), .wr_data_o(wr_data));
  uhb_host uhb_host_inst (.mclk_i(mclk_i), .dev_data_i(dout),
    .dev_oe_i(oe), .cs_n_o(cs_n), .rd_n_o(rd_n), .wr_n_o(wr_n),
    .sel_o(sel), .bus_o(bus));

  // ===================================================================
  // Helpers
  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction : rnd

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic irq_chk(input logic m);
    logic [7:0] e;
    for (int r = 0; r < 2; r++) begin
      #1 irq_req_i = r[0];
      repeat (2) @(posedge mclk_i);
      e = m ? {6'h00, r[0], mdl[`UHB_IDX_MCR][`UHB_MCR_IRQ_EN]}
            : {7'h00, r[0]};
      chk({6'h00, irq_o, irq_oe}, e);
    end
  endtask : irq_chk

  task automatic run_mode(input logic m);
    logic [7:0] d;
    int s, o;
    #1 bus_mode_i = m;
    repeat (4) @(posedge mclk_i);
    for (int i = 0; i < 8; i++) begin
      uhb_host_inst.access(m, 1'b1, 1'b1, i[2:0], 8'h00, q);
      chk(q, mdl[i][7:0]);
      chk({7'h00, oe}, 8'h00);
      d = 8'(rnd());
      s = n_stb;
      uhb_host_inst.access(m, 1'b1, 1'b0, i[2:0], d, q);
      mdl[i] = {24'h000000, d};
      chk(8'(n_stb - s), 8'h01);
      chk({5'h00, wr_sel}, {5'h00, i[2:0]});
      chk(wr_data, d);
      uhb_host_inst.access(m, 1'b0, 1'b0, i[2:0], ~d, q);
      o = n_oe;
      uhb_host_inst.access(m, 1'b0, 1'b1, i[2:0], 8'h00, q);
      chk(8'(n_oe - o), 8'h00);
      chk(8'(n_stb - s), 8'h01);
      uhb_host_inst.access(m, 1'b1, 1'b1, i[2:0], 8'h00, q);
      chk(q, d);
    end
    for (int k = 0; k < 2; k++) begin
      d = k ? 8'h00 : 8'h08;
      uhb_host_inst.access(m, 1'b1, 1'b0, `UHB_IDX_MCR, d, q);
      mdl[`UHB_IDX_MCR] = {24'h000000, d};
      irq_chk(m);
    end
    $display("test mode %0d done", m);
  endtask : run_mode

  task automatic test_done();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : test_done

  // ===================================================================
  // Main sequence and watchdog
  initial begin
    foreach (mdl[i]) mdl[i] = `UHB_RST_BYTE;
    repeat (8) @(posedge mclk_i);
    #1 rst_i = 1'b0;
    run_mode(1'b1);
    run_mode(1'b0);
    test_done();
  end

  initial begin
    repeat (6000) @(posedge mclk_i);
    n_errors++;
    test_done();
  end
endmodule : testbench
